//--- logic/vpc_top.sv
// video path control register with avalon slave and datapath steering
//
// Chosen here: the Avalon-MM slave port.
module vpc_top #(
    parameter int PIX_W = 24
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [vpc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [vpc_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [vpc_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic fwd_load_i,
    input wire logic [6:0] fwd_data_i,
    input wire logic [PIX_W-1:0] pix_i,
    input wire logic video_valid_strobe_i,
    input wire logic aux_pkt_i,
    output logic [PIX_W-1:0] pix_o,
    output logic pix_valid_o,
    output logic aux_on_pins_o,
    output logic decrypt_en_o,
    output logic audio_pkt_en_o,
    output logic inband_audio_o,
    output logic quad_audio_o,
    output logic pix18_o,
    output logic fwd_ignored_o
);
    typedef enum logic [0:0] {VPC_IDLE, VPC_ACK} vpc_state_t;

    vpc_state_t st_r;
    vpc_state_t st_nxt;
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic [vpc_pkg::DATA_W-1:0] rdata_r;
    logic [vpc_pkg::DATA_W-1:0] rdata_nxt;
    logic ign_r;
    logic ign_nxt;
    logic wr_hit;
    logic fwd_take;
    logic req;

    // one wait cycle per access: request seen in idle, answered in ack
    always_comb begin
        req = avs_read_i | avs_write_i;
        st_nxt = st_r;
        unique case (st_r)
            VPC_IDLE: begin
                if (req) begin
                    st_nxt = VPC_ACK;
                end
            end
            VPC_ACK: begin
                st_nxt = VPC_IDLE;
            end
        endcase
        if (!rst_n_i) begin
            st_nxt = VPC_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        st_r <= st_nxt;
    end

    assign avs_waitrequest_o = !(st_r == VPC_ACK);

    always_comb begin
        wr_hit = (st_r == VPC_ACK) && avs_write_i && (avs_address_i == vpc_pkg::OFF_VPC)
            && avs_byteenable_i[0];
        fwd_take = fwd_load_i && !ctl_r[vpc_pkg::BIT_FWD_BLOCK];
        ctl_nxt = ctl_r;
        if (fwd_take) begin
            ctl_nxt[6:0] = fwd_data_i & vpc_pkg::FWD_MASK;
        end
        // a local write lands last so it beats a forward load in the same cycle
        if (wr_hit) begin
            ctl_nxt = avs_writedata_i[7:0];
        end
        ign_nxt = ign_r;
        if (fwd_load_i && ctl_r[vpc_pkg::BIT_FWD_BLOCK]) begin
            ign_nxt = 1'b1;
        end else if (wr_hit) begin
            ign_nxt = 1'b0;
        end
        rdata_nxt = vpc_pkg::UNMAPPED_READ;
        if (st_r == VPC_IDLE && avs_read_i) begin
            if (avs_address_i == vpc_pkg::OFF_VPC) begin
                rdata_nxt = {24'h000000, ctl_r};
            end else if (avs_address_i == vpc_pkg::OFF_VPC_STAT) begin
                rdata_nxt = {31'h00000000, ign_r};
            end
        end else if (st_r == VPC_ACK) begin
            rdata_nxt = rdata_r;
        end
        if (!rst_n_i) begin
            ctl_nxt = vpc_pkg::VPC_RESET;
            ign_nxt = 1'b0;
            rdata_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        ctl_r <= ctl_nxt;
        ign_r <= ign_nxt;
        rdata_r <= rdata_nxt;
    end

    assign avs_readdata_o = rdata_r;
    assign fwd_ignored_o = ign_r;

    vpc_pixel_gate #(
        .PIX_W(PIX_W)
    ) u_gate (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pix_i(pix_i),
        .strobe_i(video_valid_strobe_i),
        .strobe_pol_i(ctl_r[vpc_pkg::BIT_STROBE_POL]),
        .ungated_i(ctl_r[vpc_pkg::BIT_UNGATED]),
        .pix18_i(ctl_r[vpc_pkg::BIT_PIX18]),
        .pix_o(pix_o),
        .pix_valid_o(pix_valid_o)
    );

    // steering outputs decode straight from the register bits, aux_on_pins_o from those bits and aux_pkt_i
    always_comb begin
        decrypt_en_o = !ctl_r[vpc_pkg::BIT_UNGATED];
        audio_pkt_en_o = !ctl_r[vpc_pkg::BIT_UNGATED];
        aux_on_pins_o = aux_pkt_i && !ctl_r[vpc_pkg::BIT_AUX_OFF]
            && !ctl_r[vpc_pkg::BIT_UNGATED];
        inband_audio_o = ctl_r[vpc_pkg::BIT_INBAND];
        quad_audio_o = ctl_r[vpc_pkg::BIT_QUAD_OVR] && ctl_r[vpc_pkg::BIT_QUAD_EN];
        pix18_o = ctl_r[vpc_pkg::BIT_PIX18];
    end

    // ungated pass in backward-compatible links is software's choice, not checked

    a_reset_clear: assert property (@(posedge ref_clk_i)
        !rst_n_i |=> ctl_r == 8'h00) else $error("register not cleared by reset");

    a_fwd_blocked: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        fwd_load_i && ctl_r[7] && !wr_hit |=> $stable(ctl_r))
        else $error("forward load changed blocked register");

    a_fwd_loads: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        fwd_load_i && !ctl_r[7] && !wr_hit |=> ctl_r[6:0] == $past(fwd_data_i)
        && ctl_r[7] == $past(ctl_r[7])) else $error("forward load not applied");

    a_local_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_hit |=> ctl_r == $past(avs_writedata_i[7:0]))
        else $error("local write lost");

    a_ungated_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctl_r[6] |=> pix_valid_o) else $error("ungated pixels not passed");

    a_ungated_block: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctl_r[6] |-> !decrypt_en_o && !audio_pkt_en_o && !aux_on_pins_o)
        else $error("decrypt or audio active in ungated pass");

    a_strobe_pol: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !ctl_r[6] && (video_valid_strobe_i == ctl_r[5]) |=> !pix_valid_o)
        else $error("inactive strobe passed pixels");

    a_aux_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctl_r[4] |-> !aux_on_pins_o) else $error("audio on pixel pins");

    a_quad_force: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        quad_audio_o == (ctl_r[3] & ctl_r[0])) else $error("quad audio wrong");

    sequence s_req_idle;
        avs_read_i && st_r == VPC_IDLE;
    endsequence
    a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_req_idle |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer timing wrong");
endmodule // vpc_top

//--- logic/vpc_pkg.sv
// constants shared by the video path control register block
package vpc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [7:0] OFF_VPC = 8'h22;
    localparam logic [7:0] OFF_VPC_STAT = 8'h24;
    localparam logic [7:0] VPC_RESET = 8'h00;
    localparam int BIT_FWD_BLOCK = 7;
    localparam int BIT_UNGATED = 6;
    localparam int BIT_STROBE_POL = 5;
    localparam int BIT_AUX_OFF = 4;
    localparam int BIT_QUAD_OVR = 3;
    localparam int BIT_PIX18 = 2;
    localparam int BIT_INBAND = 1;
    localparam int BIT_QUAD_EN = 0;
    localparam logic [6:0] FWD_MASK = 7'h7f;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

//--- logic/vpc_pixel_gate.sv
// pixel output gating by the video valid strobe
module vpc_pixel_gate #(
    parameter int PIX_W = 24
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [PIX_W-1:0] pix_i,
    input wire logic strobe_i,
    input wire logic strobe_pol_i,
    input wire logic ungated_i,
    input wire logic pix18_i,
    output logic [PIX_W-1:0] pix_o,
    output logic pix_valid_o
);
    logic [PIX_W-1:0] pix_r;
    logic [PIX_W-1:0] pix_nxt;
    logic valid_r;
    logic valid_nxt;
    logic strobe_act;
    logic [PIX_W-1:0] pix_mask;

    always_comb begin
        strobe_act = strobe_i ^ strobe_pol_i;
        // 18-bit mapping keeps six bits per colour, low two of each lane zero
        pix_mask = pix18_i ? {PIX_W{1'b1}} & ~PIX_W'(24'h030303) : {PIX_W{1'b1}};
        valid_nxt = strobe_act | ungated_i;
        pix_nxt = valid_nxt ? (pix_i & pix_mask) : pix_r;
        if (!rst_n_i) begin
            valid_nxt = 1'b0;
            pix_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        pix_r <= pix_nxt;
        valid_r <= valid_nxt;
    end

    assign pix_o = pix_r;
    assign pix_valid_o = valid_r;
endmodule // vpc_pixel_gate

//--- verification/vpc_ser_model.sv
// behavioural remote serializer driving forward-channel updates
module vpc_ser_model (
    input wire logic ref_clk_i,
    input wire logic go_i,
    input wire logic [6:0] val_i,
    output logic load_o,
    output logic [6:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        load_o = 1'b0;
        data_o = 7'h00;
    end
    always @(posedge ref_clk_i) begin
        load_o <= go_i;
        // data not held outside the pulse, so a late sample sees junk
        data_o <= go_i ? val_i : ~data_o;
    end
endmodule // vpc_ser_model

//--- verification/testbench.sv
// self-checking bench for the video path control register
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0, wr = 1'b0, go = 1'b0, strobe = 1'b0, load, wait_o;
    logic [31:0] wd = 32'h0, rdata, q;
    logic [6:0] sv = 7'h00, fdata;
    logic aux_o, dec_o, aud_o, inb_o, quad_o, p18_o, ign_o, pv_o;
    logic [23:0] pix_o;
    int bad_count = 0, comparisons = 0;
    // row: control byte, strobe, expected valid, {aux,decrypt,audio,inband,quad,pix18}
    // no row models a legacy link, so ungated pass is set only where wanted
    logic [15:0] rows [7] = '{16'h0bfe, 16'h5140, 16'h2479, 16'h1818, 16'h20b8,
        16'h0038, 16'h04f9};
    always #50 ref_clk_i = ~ref_clk_i;
    vpc_top vpc_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .fwd_load_i(load), .fwd_data_i(fdata), .pix_i(24'habcdef),
        .video_valid_strobe_i(strobe), .aux_pkt_i(1'b1), .pix_o(pix_o),
        .pix_valid_o(pv_o), .aux_on_pins_o(aux_o), .decrypt_en_o(dec_o),
        .audio_pkt_en_o(aud_o), .inband_audio_o(inb_o), .quad_audio_o(quad_o),
        .pix18_o(p18_o), .fwd_ignored_o(ign_o));
    vpc_ser_model vpc_ser_model_i (.ref_clk_i(ref_clk_i), .go_i(go), .val_i(sv),
        .load_o(load), .data_o(fdata));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // held until waitrequest is seen low at a rising edge
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wr <= we;
        rd <= !we;
        wd <= d;
        // waitrequest and read data are looked at as they stand at the rising edge
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 20);
        if (n >= 20) begin
            chk(32'h1, 32'h0);
            complete_run();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task fwd(input logic [6:0] v);
        sv <= v;
        go <= 1'b1;
        @(posedge ref_clk_i);
        go <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        foreach (rows[i]) begin
            bus(1'b1, 8'h22, {24'h0, rows[i][15:8]});
            strobe <= rows[i][7];
            bus(1'b0, 8'h22, 32'h0);
            chk(q, {24'h0, rows[i][15:8]});
            chk({aux_o, dec_o, aud_o, inb_o, quad_o, p18_o}, rows[i][5:0]);
            chk(pv_o, rows[i][6]);
            if (rows[i][6]) chk(pix_o, rows[i][10] ? 24'habcdef & 24'hfcfcfc : 24'habcdef);
        end
        // reset in mid-run must clear every bit
        rst_n_i <= 1'b0;
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        bus(1'b0, 8'h22, 32'h0);
        chk(q, 32'h0);
        fwd(7'h2a);
        bus(1'b0, 8'h22, 32'h0);
        chk(q, 32'h2a);
        bus(1'b1, 8'h22, 32'h80);
        fwd(7'h55);
        bus(1'b0, 8'h22, 32'h0);
        chk(q, 32'h80);
        chk(ign_o, 32'h1);
        bus(1'b1, 8'h22, 32'h95);
        bus(1'b0, 8'h22, 32'h0);
        chk(q, 32'h95);
        // unmapped place: write dropped, read gives zero
        bus(1'b1, 8'h30, 32'hff);
        bus(1'b0, 8'h30, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 8'h22, 32'h0);
        chk(q, 32'h95);
        complete_run();
    end
endmodule // testbench
